// [common/bbc_pkg.sv]
package bbc_pkg;

  // ==========================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLEW_STEP_NS = 32_000;
  localparam int SLEW_CYC = (SLEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] SLEW_LAST = 10'(SLEW_CYC - 1);
  localparam int SW_HI_HZ = 1_000_000;
  localparam int SW_LO_HZ = 500_000;
  localparam logic [4:0] SW_HALF_HI = 5'(CLK_HZ / (2 * SW_HI_HZ) - 1);
  localparam logic [4:0] SW_HALF_LO = 5'(CLK_HZ / (2 * SW_LO_HZ) - 1);
  localparam logic [2:0] OV_FAULT_RESTARTS = 3'h4;

  // ==========================================
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_OUTCUR = 8'h00;
  localparam logic [7:0] ADDR_SWCTRL = 8'h04;
  localparam logic [7:0] ADDR_GLOBAL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ==========================================
  // Fields and reset values
  localparam logic [7:0] OUTCUR_RST = 8'h40;
  localparam logic [7:0] SWCTRL_RST = 8'h02;
  localparam logic [7:0] SWCTRL_RW_MASK = 8'hcf;
  localparam int SWCTRL_CLKSEL_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_RAMP_BIT = 1;
  localparam int STAT_CODE_LSB = 8;
  localparam int GLOBAL_EN_BIT = 0;
  localparam int IRQ_W = 3;
  localparam int IRQ_RAMP_DONE = 0;
  localparam int IRQ_OV_RESTART = 1;
  localparam int IRQ_OV_FAULT = 2;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // ==========================================
  // Types
  typedef struct packed {
    logic en;
    logic scale_full;
    logic rsvd;
    logic [4:0] code;
  } bbc_outcur_type;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } bbc_ahb_in_type;

  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
  } bbc_ahb_out_type;

  typedef enum {ST_OFF, ST_START, ST_RUN} bbc_state_type;

endpackage

// [logic/bbc_swclk_div.sv]
module bbc_swclk_div (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_run,
  input wire logic i_sel_hi,
  // Switching clock
  output logic o_sw_clk
);
  import bbc_pkg::*;

  logic [4:0] cnt_q, cnt_d;
  logic sw_q, sw_d;
  logic [4:0] half;

  // Half period picked by rate select; held low while off
  always_comb begin
    half = i_sel_hi ? SW_HALF_HI : SW_HALF_LO;
    cnt_d = cnt_q + 5'h01;
    sw_d = sw_q;
    if (!i_run) begin
      cnt_d = 5'h00;
      sw_d = 1'b0;
    end else if (cnt_q >= half) begin // Rate change mid-period still ends cleanly
      cnt_d = 5'h00;
      sw_d = !sw_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 5'h00;
      sw_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sw_q <= sw_d;
    end
  end

  assign o_sw_clk = sw_q;

  // ==========================================
  // Checks
  chk_sw_half_period: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ($changed(sw_q) && $past(i_run) && i_run && $stable(i_sel_hi) && $past(i_sel_hi, 2) == i_sel_hi)
      |-> $past(cnt_q) == (i_sel_hi ? SW_HALF_HI : SW_HALF_LO))
    else $error("switching clock half period wrong");

endmodule

// [logic/bbc_ctrl.sv]
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
module bbc_ctrl (
  // Clock and power-on reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Register bus
  input wire bbc_pkg::bbc_ahb_in_type I_AHB,
  output bbc_pkg::bbc_ahb_out_type O_AHB,
  // Power stage
  input wire logic I_OV_SENSE,
  output logic O_CONV_EN,
  output logic [4:0] O_SINK_CODE,
  output logic O_SCALE_FULL,
  output logic O_SW_CLK,
  output logic O_LOOP_RST,
  // Interrupt
  output logic O_IRQ
);
  import bbc_pkg::*;

  // ==========================================
  // Declarations
  bbc_outcur_type outcur_q, outcur_d;
  logic [7:0] swctrl_q, swctrl_d;
  logic glob_en_q, glob_en_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [IRQ_W-1:0] irq_evt, irq_clr;
  bbc_outcur_type wr_outcur;
  logic wr_pend_q, wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  bbc_ahb_out_type ahb_q, ahb_d;
  logic irq_q, irq_d;
  logic addr_ok;
  bbc_state_type state_q, state_d;
  logic [4:0] applied_q, applied_d;
  logic [9:0] slew_cnt_q, slew_cnt_d;
  logic [2:0] restart_cnt_q, restart_cnt_d;
  logic conv_en_q, conv_en_d;
  logic loop_rst_q, loop_rst_d;
  logic run_req, ramp_active, step_tick, restart;
  logic ramp_done, fault_evt;
  logic rst_seen_q;

  // ==========================================
  // Converter control
  // Both enables must be high; registers survive a drop of either
  assign run_req = glob_en_q && outcur_q.en;
  // Ramp runs whenever the sequencer is not off and the applied code differs from the programmed one
  assign ramp_active = (state_q != ST_OFF) && (applied_q != outcur_q.code);
  assign step_tick = ramp_active && (slew_cnt_q == SLEW_LAST);
  // Over-voltage acts at once when running, per step while soft starting
  assign restart = I_OV_SENSE && run_req && ((state_q == ST_RUN) || step_tick);

  // Next state of the converter sequencer
  always_comb begin
    state_d = state_q;
    applied_d = applied_q;
    restart_cnt_d = restart_cnt_q;
    loop_rst_d = 1'b0;
    fault_evt = 1'b0;
    slew_cnt_d = ramp_active ? slew_cnt_q + 10'h001 : 10'h000;
    if (step_tick) begin
      slew_cnt_d = 10'h000;
    end
    case (state_q)
      ST_OFF: begin
        applied_d = 5'h00;
        restart_cnt_d = 3'h0;
        if (run_req) begin
          state_d = ST_START;
        end
      end
      ST_START, ST_RUN: begin
        if (!run_req) begin
          state_d = ST_OFF;
          applied_d = 5'h00;
        end else if (restart) begin
          // Hiccup: drop to the bottom code and soft start again
          state_d = ST_START;
          applied_d = 5'h00;
          loop_rst_d = 1'b1;
          slew_cnt_d = 10'h000;
          if (restart_cnt_q != OV_FAULT_RESTARTS) begin
            restart_cnt_d = restart_cnt_q + 3'h1;
            fault_evt = (restart_cnt_q + 3'h1) == OV_FAULT_RESTARTS;
          end
        end else begin
          if (step_tick) begin
            // One code per step, either direction
            applied_d = (applied_q < outcur_q.code) ? applied_q + 5'h01 : applied_q - 5'h01;
          end
          if (state_q == ST_START && applied_q == outcur_q.code) begin
            state_d = ST_RUN;
          end
          // A clean sense while running ends the hiccup streak
          if (state_q == ST_RUN && !I_OV_SENSE) begin
            restart_cnt_d = 3'h0;
          end
        end
      end
      default: begin
        state_d = ST_OFF;
        applied_d = 5'h00;
      end
    endcase
    conv_en_d = (state_d != ST_OFF);
  end

  assign ramp_done = step_tick && !restart && run_req && (applied_d == outcur_q.code);

  // Sequencer registers; power-on reset forces the converter off
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= ST_OFF;
      applied_q <= 5'h00;
      slew_cnt_q <= 10'h000;
      restart_cnt_q <= 3'h0;
      conv_en_q <= 1'b0;
      loop_rst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      applied_q <= applied_d;
      slew_cnt_q <= slew_cnt_d;
      restart_cnt_q <= restart_cnt_d;
      conv_en_q <= conv_en_d;
      loop_rst_q <= loop_rst_d;
    end
  end

  // ==========================================
  // Bus slave and registers
  assign addr_ok = I_AHB.hsel && I_AHB.htrans[HTRANS_ACTIVE_BIT] && I_AHB.hready;

  // Zero-wait slave: read data captured in the address phase
  always_comb begin
    outcur_d = outcur_q;
    swctrl_d = swctrl_q;
    glob_en_d = glob_en_q;
    irq_mask_d = irq_mask_q;
    irq_clr = '0;
    // Write data seen through the register layout, so no field position is hand-coded
    wr_outcur = bbc_outcur_type'(I_AHB.hwdata[$bits(bbc_outcur_type)-1:0]);
    wr_pend_d = addr_ok && I_AHB.hwrite;
    wr_addr_d = addr_ok ? I_AHB.haddr[ADDR_W-1:0] : wr_addr_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        ADDR_OUTCUR: begin
          outcur_d.en = wr_outcur.en;
          outcur_d.rsvd = wr_outcur.rsvd;
          // Scale and code settings frozen while a ramp is under way; enable still writable
          if (!ramp_active) begin
            outcur_d.scale_full = wr_outcur.scale_full;
            outcur_d.code = wr_outcur.code;
          end
        end
        ADDR_SWCTRL: swctrl_d = I_AHB.hwdata[$bits(swctrl_q)-1:0] & SWCTRL_RW_MASK;
        ADDR_GLOBAL: glob_en_d = I_AHB.hwdata[GLOBAL_EN_BIT];
        ADDR_IRQ_STAT: irq_clr = I_AHB.hwdata[IRQ_W-1:0];
        ADDR_IRQ_MASK: irq_mask_d = I_AHB.hwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    irq_evt = '0;
    irq_evt[IRQ_RAMP_DONE] = ramp_done;
    irq_evt[IRQ_OV_RESTART] = loop_rst_d;
    irq_evt[IRQ_OV_FAULT] = fault_evt;
    // Set beats a same-cycle write-one clear
    irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
    irq_d = |(irq_stat_d & irq_mask_d);
    ahb_d.hreadyout = 1'b1;
    ahb_d.hresp = 1'b0;
    ahb_d.hrdata = 32'h0000_0000;
    if (addr_ok && !I_AHB.hwrite) begin
      case (I_AHB.haddr[ADDR_W-1:0])
        ADDR_OUTCUR: ahb_d.hrdata = 32'(outcur_q);
        ADDR_SWCTRL: ahb_d.hrdata = 32'(swctrl_q);
        ADDR_GLOBAL: ahb_d.hrdata = 32'(glob_en_q);
        ADDR_STATUS: begin
          ahb_d.hrdata = 32'(applied_q) << STAT_CODE_LSB;
          ahb_d.hrdata[STAT_RUN_BIT] = conv_en_q;
          ahb_d.hrdata[STAT_RAMP_BIT] = ramp_active;
        end
        ADDR_IRQ_STAT: ahb_d.hrdata = 32'(irq_stat_q);
        ADDR_IRQ_MASK: ahb_d.hrdata = 32'(irq_mask_q);
        default: ahb_d.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Defaults are loaded by power-on reset alone
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      outcur_q <= OUTCUR_RST;
      swctrl_q <= SWCTRL_RST;
      glob_en_q <= 1'b0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      ahb_q <= '{hreadyout: 1'b1, hrdata: 32'h0000_0000, hresp: 1'b0};
      irq_q <= 1'b0;
      rst_seen_q <= 1'b0;
    end else begin
      outcur_q <= outcur_d;
      swctrl_q <= swctrl_d;
      glob_en_q <= glob_en_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      ahb_q <= ahb_d;
      irq_q <= irq_d;
      rst_seen_q <= 1'b1;
    end
  end

  // ==========================================
  // Outputs and switching clock
  assign O_AHB = ahb_q;
  assign O_CONV_EN = conv_en_q;
  assign O_SINK_CODE = applied_q;
  assign O_SCALE_FULL = outcur_q.scale_full;
  assign O_LOOP_RST = loop_rst_q;
  assign O_IRQ = irq_q;

  // Rate select steers the divider
  bbc_swclk_div bbc_swclk_div_i (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_run(conv_en_q),
    .i_sel_hi(swctrl_q[SWCTRL_CLKSEL_BIT]),
    .o_sw_clk(O_SW_CLK)
  );

  // ==========================================
  // Checks
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  chk_reset_defaults: assert property (!rst_seen_q |->
    (outcur_q == OUTCUR_RST && swctrl_q == SWCTRL_RST && !O_CONV_EN))
    else $error("settings not at defaults after reset");

  chk_off_after_reset: assert property ((!rst_seen_q ##1 !outcur_q.en [*2]) |-> !O_CONV_EN)
    else $error("converter ran without local enable");

  chk_enables_gate: assert property (!(glob_en_q && outcur_q.en) |=> !O_CONV_EN)
    else $error("converter on without both enables");

  chk_keep_settings: assert property ((O_CONV_EN && !run_req && !wr_pend_q) |=> $stable(outcur_q.code))
    else $error("disable altered stored settings");

  chk_soft_start: assert property ((state_q == ST_OFF && run_req)
    |=> (state_q == ST_START && O_SINK_CODE == 5'h00 && O_CONV_EN))
    else $error("soft start did not begin");

  chk_start_ends: assert property ((state_q == ST_START && run_req && !restart
    && applied_q == outcur_q.code) |=> state_q == ST_RUN)
    else $error("soft start did not end at target");

  chk_step_timing: assert property (($changed(applied_q) && $past(run_req)
    && !$past(loop_rst_d) && $past(state_q) != ST_OFF) |-> $past(slew_cnt_q) == SLEW_LAST)
    else $error("code stepped off the slew timer");

  chk_step_size: assert property ($past(step_tick && !restart && run_req)
    |-> (applied_q == $past(applied_q) + 5'h01 || applied_q == $past(applied_q) - 5'h01))
    else $error("ramp step not one code");

  chk_ramp_freeze: assert property (ramp_active |=> $stable(outcur_q.code))
    else $error("setting changed during ramp");

  chk_run_write: assert property ((wr_pend_q && wr_addr_q == ADDR_OUTCUR && !ramp_active
    && O_CONV_EN) |=> outcur_q.code == $past(wr_outcur.code))
    else $error("running write not accepted");

  // Flag up and the step timer running, or wrapping at the step instant
  chk_ramp_flag: assert property ((state_q != ST_OFF && applied_q != outcur_q.code && !restart)
    |-> ramp_active ##1 (slew_cnt_q == ($past(step_tick) ? 10'h000 : $past(slew_cnt_q) + 10'h001)))
    else $error("ramp flag or timer wrong");

  chk_ov_restart: assert property ((restart && run_req) |=>
    (O_LOOP_RST && O_SINK_CODE == 5'h00 && state_q == ST_START))
    else $error("over-voltage did not restart soft start");

  chk_ov_fault: assert property (fault_evt |=> irq_stat_q[IRQ_OV_FAULT])
    else $error("fault not flagged");

  chk_irq_level: assert property (O_IRQ == ((irq_stat_q & irq_mask_q) != '0))
    else $error("interrupt level disagrees with pending unmasked bits");

  cov_soft_start_done: cover property (state_q == ST_START ##1 state_q == ST_RUN);
  cov_ramp_done: cover property (ramp_done);
  cov_ov_fault: cover property (fault_evt);
  cov_irq: cover property ($rose(O_IRQ));

endmodule

// [verification/bbc_stage_model.sv]
module bbc_stage_model (
  // Clock
  input wire logic i_clk,
  // Drive from the controller
  input wire logic i_conv_en,
  input wire logic i_loop_rst,
  // Fault injection from the bench
  input wire logic i_open_string,
  // Over-voltage comparator
  output logic o_ov_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Comparator output
  initial o_ov_sense = 1'b0;
  // An open string lets the output climb past the trip while switching;
  // a loop reset only dips the trip for a cycle, the cause stays, so it comes back
  always @(posedge i_clk) begin
    o_ov_sense <= i_conv_en & i_open_string & !i_loop_rst;
  end
endmodule

// [verification/test_backlight_boost_enable_slew_ctrl.sv]
module test_backlight_boost_enable_slew_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import bbc_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  typedef struct {logic [7:0] a; logic [31:0] rst; logic [31:0] wd; logic [31:0] exp;} bbc_row_type;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic open_string = 1'b0;
  logic ov_sense;
  bbc_ahb_in_type ahb_in;
  bbc_ahb_out_type ahb_out;
  logic conv_en;
  logic sw_clk;
  logic loop_rst;
  logic scale_full;
  logic irq;
  logic [4:0] sink_code;
  logic [31:0] rd;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  bbc_row_type rows [7] = '{
    '{8'h00, 32'h40, 32'h25, 32'h25}, '{8'h04, 32'h02, 32'hff, 32'hcf},
    '{8'h08, 32'h00, 32'hff, 32'h01}, '{8'h0c, 32'h00, 32'hff, 32'h00},
    '{8'h10, 32'h00, 32'hff, 32'h00}, '{8'h14, 32'h00, 32'h07, 32'h07},
    '{8'h1c, 32'h00, 32'hff, 32'h00}};
  // ==========================================
  // Clock, bus wiring and the units under test
  always #25 clk = ~clk;
  // Single slave, so its ready is the bus ready
  assign ahb_in = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, ahb_out.hreadyout};
  bbc_ctrl bbc_ctrl_i (.I_CLK(clk), .I_RESET_N(reset_n), .I_AHB(ahb_in), .O_AHB(ahb_out),
    .I_OV_SENSE(ov_sense), .O_CONV_EN(conv_en), .O_SINK_CODE(sink_code), .O_SCALE_FULL(scale_full),
    .O_SW_CLK(sw_clk), .O_LOOP_RST(loop_rst), .O_IRQ(irq));
  bbc_stage_model bbc_stage_model_i (.i_clk(clk), .i_conv_en(conv_en), .i_loop_rst(loop_rst),
    .i_open_string(open_string), .o_ov_sense(ov_sense));
  // ==========================================
  // Verdict, compare and bus tasks
  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One transfer; holds each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (ahb_out.hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (ahb_out.hreadyout !== 1'b1) @(posedge clk);
    rd = ahb_out.hrdata;
    chk("hresp", 32'(ahb_out.hresp), 32'h0);
  endtask
  // Land just after an edge so register outputs have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_code(input logic [4:0] t);
    n = 0;
    while (sink_code !== t && n < 2000) begin
      cyc(1);
      n++;
    end
  endtask
  // Edges between two rising edges of the switching clock
  task automatic sw_period();
    logic p;
    @(posedge sw_clk);
    n = 0;
    p = 1'b1;
    while (!(sw_clk === 1'b1 && p === 1'b0) && n < 200) begin
      p = sw_clk;
      cyc(1);
      n++;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    chk("conv_en", 32'(conv_en), 32'h0);
    chk("scale_full", 32'(scale_full), 32'h1);
    chk("sink_code", 32'(sink_code), 32'h0);
    // Reset value, write, read back for every register
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk("reset value", rd, rows[i].rst);
      bus(1'b1, rows[i].a, rows[i].wd);
      bus(1'b0, rows[i].a, 32'h0);
      chk("read back", rd, rows[i].exp);
    end
    cyc(3);
    chk("conv_en", 32'(conv_en), 32'h0);
    // Local enable with code 3 in the same write
    bus(1'b1, 8'h00, 32'hc3);
    cyc(2);
    chk("conv_en", 32'(conv_en), 32'h1);
    chk("sink_code", 32'(sink_code), 32'h0);
    wait_code(5'h1);
    wait_code(5'h2);
    chk("step cycles", n, 32'h280);
    bus(1'b1, 8'h00, 32'hdf);
    bus(1'b0, 8'h00, 32'h0);
    chk("outcur in ramp", rd, 32'hc3);
    bus(1'b0, 8'h0c, 32'h0);
    chk("status in ramp", rd, 32'h203);
    wait_code(5'h3);
    cyc(3);
    bus(1'b0, 8'h0c, 32'h0);
    chk("status", rd, 32'h301);
    chk("irq", 32'(irq), 32'h1);
    bus(1'b1, 8'h10, 32'h1);
    cyc(2);
    chk("irq", 32'(irq), 32'h0);
    // New half-scale setting while running, after the ramp ended
    bus(1'b1, 8'h00, 32'h84);
    cyc(2);
    chk("scale_full", 32'(scale_full), 32'h0);
    wait_code(5'h4);
    chk("sink_code", 32'(sink_code), 32'h4);
    sw_period();
    chk("sw period", n, 32'h14);
    bus(1'b1, 8'h04, 32'h0);
    sw_period();
    chk("sw period", n, 32'h28);
    // Global off keeps the stored settings
    bus(1'b1, 8'h08, 32'h0);
    cyc(2);
    chk("conv_en", 32'(conv_en), 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk("outcur kept", rd, 32'h84);
    // Open string while enabling again
    bus(1'b1, 8'h10, 32'h7);
    open_string <= 1'b1;
    bus(1'b1, 8'h08, 32'h1);
    n = 0;
    while (loop_rst !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk("loop_rst", 32'(loop_rst), 32'h1);
    chk("sink_code", 32'(sink_code), 32'h0);
    cyc(3000);
    bus(1'b0, 8'h10, 32'h0);
    chk("irq stat", rd, 32'h6);
    chk("irq", 32'(irq), 32'h1);
    bus(1'b1, 8'h14, 32'h0);
    cyc(2);
    chk("irq masked", 32'(irq), 32'h0);
    // Reset in mid-run reloads the defaults
    @(posedge clk);
    open_string <= 1'b0;
    reset_n <= 1'b0;
    cyc(2);
    chk("conv_en", 32'(conv_en), 32'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk("outcur default", rd, 32'h40);
    bus(1'b0, 8'h04, 32'h0);
    chk("swctrl default", rd, 32'h02);
    bus(1'b0, 8'h08, 32'h0);
    chk("global default", rd, 32'h0);
    chk("conv_en", 32'(conv_en), 32'h0);
    end_sim();
  end
  // ==========================================
  // Watchdog, well past the expected run of some 6400 cycles
  initial begin
    #2_000_000;
    bad_count++;
    end_sim();
  end
endmodule
